/* psm_cfg.svh */
// Purpose: Constants for the power saving mode controller
// Assumes: Included by bare name
// Notes:   Offsets are byte addresses on the plain register port
`ifndef PSM_CFG_SVH
`define PSM_CFG_SVH

`define PSM_ADDR_W        4
`define PSM_OFF_CTRL      4'h0
`define PSM_OFF_STATUS    4'h4
// Control register fields
`define PSM_CTRL_SLOW     0
`define PSM_CTRL_PRE_LO   1
`define PSM_CTRL_PRE_HI   2
`define PSM_CTRL_TBIE     3
`define PSM_CTRL_LONG     4
`define PSM_CTRL_RESET    5'h00
// Status register fields
`define PSM_STAT_MODE_LO  0
`define PSM_STAT_MODE_HI  2
`define PSM_STAT_SLOW     3
`define PSM_STAT_PRIO_LO  4
`define PSM_STAT_PRIO_HI  5
`define PSM_STAT_GUARD    6
// Priority mask values
`define PSM_PRIO_ENABLE   2'h2
`define PSM_PRIO_RESET    2'h3
// Stabilisation delays in master clock cycles
`define PSM_STAB_SHORT    13'h0100
`define PSM_STAB_LONG     13'h1000
`define PSM_STAB_ONE      13'h0001
`define PSM_DIV_ONE       4'h1
`define PSM_DIV_BASE      5'h02

`endif

/* psm_pkg.sv */
// Purpose: Types for the power saving mode controller
// Assumes: Nothing
// Notes:   The divider, counter and top modules keep all their state in one struct from here
`default_nettype none
package psm_pkg;

  typedef enum logic [2:0] {
    PSM_ACTIVE = 3'h0,
    PSM_WAIT   = 3'h1,
    PSM_AHALT  = 3'h2,
    PSM_HALT   = 3'h3,
    PSM_STAB   = 3'h4
  } psm_mode_t;

  typedef struct packed {
    logic [3:0] cnt;
    logic       tick;
  } psm_div_t;

  typedef struct packed {
    logic [12:0] cnt;
    logic        busy;
    logic        done;
  } psm_stab_t;

  typedef struct packed {
    psm_mode_t  mode;
    logic [4:0] ctrl;
    logic [1:0] prio;
    logic [1:0] saved_prio;
    logic       guard;
    logic       ccr_push;
    logic       wake_irq;
    logic       cpu_reset;
    logic [7:0] rdata;
    logic [2:0] rst_sync;
    logic       rst_req;
    logic       stab_rst;
  } psm_top_t;

endpackage
`default_nettype wire

/* psm_clkdiv.sv */
// Purpose: Slow clock enable divider, master clock divided by 2, 4, 8 or 16
// Assumes: One clock, synchronous active high reset
// Notes:   tick is a one-cycle enable pulse
`include "psm_cfg.svh"
`default_nettype none
module psm_clkdiv (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic [1:0] sel,
  output logic            tick
);
  psm_pkg::psm_div_t st_reg;
  psm_pkg::psm_div_t st_next;
  logic [4:0]        span;

  // Divide ratio mask: 2 << sel, minus one
  always_comb begin
    span = `PSM_DIV_BASE << sel;
    st_next = st_reg;
    st_next.cnt = st_reg.cnt + `PSM_DIV_ONE;
    st_next.tick = 1'b0;
    if ((st_reg.cnt & 4'(span - 5'h01)) == 4'(span - 5'h01)) begin
      st_next.cnt = 4'h0;
      st_next.tick = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clock) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick = st_reg.tick;
endmodule // psm_clkdiv
`default_nettype wire

/* psm_stab.sv */
// Purpose: Oscillator stabilisation and wake guard counter
// Assumes: One clock, synchronous active high reset
// Notes:   start loads 256 or 4096 cycles; done pulses once at the end
`include "psm_cfg.svh"
`default_nettype none
module psm_stab (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic start,
  input  wire logic long_sel,
  output logic      busy,
  output logic      done
);
  psm_pkg::psm_stab_t st_reg;
  psm_pkg::psm_stab_t st_next;

  // Down counter, reload on start
  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    if (start) begin
      st_next.cnt = (long_sel ? `PSM_STAB_LONG : `PSM_STAB_SHORT) - `PSM_STAB_ONE;
      st_next.busy = 1'b1;
    end else if (st_reg.busy) begin
      if (st_reg.cnt == 13'h0000) begin
        st_next.busy = 1'b0;
        st_next.done = 1'b1;
      end else begin
        st_next.cnt = st_reg.cnt - `PSM_STAB_ONE;
      end
    end
  end

  // State register
  always_ff @(posedge clock) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign busy = st_reg.busy;
  assign done = st_reg.done;
endmodule // psm_stab
`default_nettype wire

/* psm_top.sv */
// Purpose: Power saving mode controller: run, slow, wait, active-halt, halt
// Assumes: clock is the master clock; rst synchronous active high
// Notes:   Clock gating is expressed as one-cycle enable pulses
// Functional notes
// RL1: After reset, run mode with CPU and peripherals on the master clock.
// RL2: Slow mode divides master clock by 2, 4, 8 or 16 per prescale.
// RL3: Wait entered during slow mode keeps the reduced clock rate.
// RL4: Wait stops the CPU; peripherals stay clocked.
// RL5: Entering wait forces priority mask to 10; nothing else changes.
// RL6: Wait lasts until interrupt or reset, then service routine runs.
// RL7: Halt instruction: active-halt if timebase enable set, else full halt.
// RL8: Active-halt exits on interrupt immediately, without stabilisation delay.
// RL9: Stabilisation delay on active-halt exit only for reset.
// RL10: Active-halt entry forces mask to 10; pending interrupt wakes at once.
// RL11: In active-halt only oscillator and timebase run.
// RL12: Active-halt with timebase enable set blocks watchdog reset.
// RL13: Clearing timebase enable during post-wake delay gives full halt remainder.
// RL14: Wake service pushes condition code, sets level, restores on pop.
// RL15: Flash variant: only reset or timebase wakes active-halt.
// RL16: Full halt exit restarts oscillator, waits 256 or 4096 cycles.
// RL17: After wake, run or slow clocking resumes with settings unchanged.
`include "psm_cfg.svh"
`default_nettype none
module psm_top #(
  parameter bit FLASH_VARIANT = 1'b1
) (
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire logic [`PSM_ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]            reg_wdata,
  input  wire logic                  reg_we,
  input  wire logic                  reg_re,
  output logic      [7:0]            reg_rdata,
  input  wire logic                  wait_for_irq_instr,
  input  wire logic                  halt_instr,
  input  wire logic                  irq_pending,
  input  wire logic                  irq_halt_wake,
  input  wire logic                  irq_ahalt_wake,
  input  wire logic                  timebase_irq,
  input  wire logic [1:0]            irq_level,
  input  wire logic                  cpu_prio_we,
  input  wire logic [1:0]            cpu_prio_wdata,
  input  wire logic                  cpu_iret,
  input  wire logic                  reset_pin_req,
  output logic                       cpu_clk_en,
  output logic                       periph_clk_en,
  output logic                       timebase_clk_en,
  output logic                       osc_on,
  output logic                       wdg_reset_block,
  output logic      [1:0]            condition_code_prio,
  output logic                       condition_code_push,
  output logic                       wake_irq_service,
  output logic                       cpu_reset_out
);
  psm_pkg::psm_top_t st_reg;
  psm_pkg::psm_top_t st_next;
  logic              div_tick;
  logic              rate_en;
  logic              stab_start;
  logic              stab_busy;
  logic              stab_done;
  logic              slow_mode_select;
  logic [1:0]        slow_clock_prescale;
  logic              timebase_irq_enable;
  logic              rst_edge;
  logic              ahalt_wake;

  // Field aliases of the clock control/status register
  assign slow_mode_select    = st_reg.ctrl[`PSM_CTRL_SLOW];
  assign slow_clock_prescale = st_reg.ctrl[`PSM_CTRL_PRE_HI:`PSM_CTRL_PRE_LO];
  assign timebase_irq_enable = st_reg.ctrl[`PSM_CTRL_TBIE];

  psm_clkdiv u_div (
    .clock (clock),
    .rst   (rst),
    .sel   (slow_clock_prescale),
    .tick  (div_tick)
  );

  psm_stab u_stab (
    .clock    (clock),
    .rst      (rst),
    .start    (stab_start),
    .long_sel (st_reg.ctrl[`PSM_CTRL_LONG]),
    .busy     (stab_busy),
    .done     (stab_done)
  );

  // CPU rate: full master clock in run, divided in slow [RL1] [RL2]
  assign rate_en = slow_mode_select ? div_tick : 1'b1;
  // Reset pin request counts once synchroniser stages two and three agree
  assign rst_edge = st_reg.rst_sync[2] & st_reg.rst_sync[1] & ~st_reg.rst_req;
  // Flash parts wake from active-halt on timebase or reset only; this term holds the interrupt sources [RL15]
  assign ahalt_wake = timebase_irq | (irq_ahalt_wake & ~FLASH_VARIANT);

  // Next state of the whole controller
  always_comb begin
    st_next = st_reg;
    stab_start = 1'b0;
    st_next.ccr_push = 1'b0;
    st_next.wake_irq = 1'b0;
    st_next.cpu_reset = 1'b0;
    st_next.rst_sync = {st_reg.rst_sync[1:0], reset_pin_req};
    if (st_reg.rst_sync[2] == st_reg.rst_sync[1]) begin
      st_next.rst_req = st_reg.rst_sync[2];
    end
    // Register writes; read data one cycle later
    if (reg_we && reg_addr == `PSM_OFF_CTRL) begin
      st_next.ctrl = reg_wdata[4:0];
    end
    st_next.rdata = 8'h00;
    if (reg_re && reg_addr == `PSM_OFF_CTRL) begin
      st_next.rdata = {3'h0, st_reg.ctrl};
    end else if (reg_re && reg_addr == `PSM_OFF_STATUS) begin
      st_next.rdata = {1'b0, st_reg.guard, st_reg.prio, slow_mode_select, st_reg.mode};
    end
    // Priority mask normal updates and restore on return [RL14]
    if (cpu_prio_we) begin
      st_next.prio = cpu_prio_wdata;
    end else if (cpu_iret) begin
      st_next.prio = st_reg.saved_prio; // [RL14]
    end
    unique case (st_reg.mode)
      psm_pkg::PSM_ACTIVE: begin
        if (st_reg.guard && !stab_busy) begin
          st_next.guard = 1'b0;
        end else if (st_reg.guard && !timebase_irq_enable) begin
          st_next.mode = psm_pkg::PSM_HALT; // [RL13]
        end
        if (wait_for_irq_instr) begin
          st_next.mode = psm_pkg::PSM_WAIT; // [RL3] [RL4]
          st_next.prio = `PSM_PRIO_ENABLE; // [RL5]
        end else if (halt_instr) begin
          st_next.prio = `PSM_PRIO_ENABLE; // [RL10]
          st_next.guard = 1'b0;
          if (timebase_irq_enable) begin
            st_next.mode = psm_pkg::PSM_AHALT; // [RL7]
          end else begin
            st_next.mode = psm_pkg::PSM_HALT; // [RL7]
          end
        end
      end
      psm_pkg::PSM_WAIT: begin
        if (rst_edge) begin
          st_next.mode = psm_pkg::PSM_ACTIVE; // [RL6]
          st_next.cpu_reset = 1'b1;
        end else if (irq_pending) begin
          st_next.mode = psm_pkg::PSM_ACTIVE; // [RL6] [RL17]
          st_next.wake_irq = 1'b1;
        end
      end
      psm_pkg::PSM_AHALT: begin
        if (rst_edge) begin
          // Reset wake waits for the oscillator; the reset pulse comes at the end
          st_next.mode = psm_pkg::PSM_STAB; // [RL9]
          st_next.stab_rst = 1'b1;
          stab_start = 1'b1;
        end else if (ahalt_wake) begin
          st_next.mode = psm_pkg::PSM_ACTIVE; // [RL8] [RL17]
          st_next.wake_irq = 1'b1;
          st_next.guard = 1'b1;
          stab_start = 1'b1; // Guard window for the enable bit [RL13]
        end
      end
      psm_pkg::PSM_HALT: begin
        if (st_reg.guard) begin
          if (stab_done) begin
            st_next.mode = psm_pkg::PSM_ACTIVE; // [RL13]
            st_next.guard = 1'b0;
          end
        end else if (rst_edge || irq_halt_wake) begin
          st_next.mode = psm_pkg::PSM_STAB; // [RL16]
          st_next.stab_rst = rst_edge;
          stab_start = 1'b1;
        end
      end
      psm_pkg::PSM_STAB: begin
        if (stab_done) begin
          st_next.mode = psm_pkg::PSM_ACTIVE; // [RL16]
          // Reset-caused exits fetch the reset vector, others take the interrupt
          st_next.cpu_reset = st_reg.stab_rst; // [RL9]
          st_next.wake_irq = ~st_reg.stab_rst;
          st_next.stab_rst = 1'b0;
        end
      end
      default: begin
        st_next.mode = psm_pkg::PSM_ACTIVE;
      end
    endcase
    // Push condition code and raise to routine level on service [RL14]
    if (st_next.wake_irq) begin
      st_next.ccr_push = 1'b1;
      st_next.saved_prio = st_next.prio;
      st_next.prio = irq_level;
    end
  end

  // State register; reset lands in run mode with interrupts masked [RL1]
  always_ff @(posedge clock) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.mode <= psm_pkg::PSM_ACTIVE;
      st_reg.ctrl <= `PSM_CTRL_RESET;
      st_reg.prio <= `PSM_PRIO_RESET;
      st_reg.saved_prio <= `PSM_PRIO_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // Clock enables per mode [RL4] [RL11] [RL12]
  assign cpu_clk_en      = (st_reg.mode == psm_pkg::PSM_ACTIVE) & rate_en;
  assign periph_clk_en   = (st_reg.mode == psm_pkg::PSM_ACTIVE ||
                            st_reg.mode == psm_pkg::PSM_WAIT) & rate_en;
  assign timebase_clk_en = (st_reg.mode != psm_pkg::PSM_HALT);
  assign osc_on          = (st_reg.mode != psm_pkg::PSM_HALT);
  assign wdg_reset_block = (st_reg.mode == psm_pkg::PSM_AHALT); // [RL12]
  assign condition_code_prio = st_reg.prio;
  assign condition_code_push = st_reg.ccr_push;
  assign wake_irq_service    = st_reg.wake_irq;
  assign cpu_reset_out       = st_reg.cpu_reset;
  assign reg_rdata           = st_reg.rdata;

  // Checks on the controller
  a_wait_entry: assert property (@(posedge clock) disable iff (rst) // [RL5]
    (st_reg.mode == psm_pkg::PSM_ACTIVE && wait_for_irq_instr && !cpu_prio_we)
      |=> (st_reg.mode == psm_pkg::PSM_WAIT && st_reg.prio == `PSM_PRIO_ENABLE))
    else $error("wait entry wrong");
  a_cpu_stopped: assert property (@(posedge clock) disable iff (rst) // [RL4]
    (st_reg.mode != psm_pkg::PSM_ACTIVE) |-> !cpu_clk_en)
    else $error("cpu clocked outside run");
  a_wait_periph: assert property (@(posedge clock) disable iff (rst) // [RL4]
    (st_reg.mode == psm_pkg::PSM_WAIT && !slow_mode_select) |-> periph_clk_en)
    else $error("peripherals stopped in wait");
  a_wait_wake: assert property (@(posedge clock) disable iff (rst) // [RL6]
    (st_reg.mode == psm_pkg::PSM_WAIT && irq_pending && !rst_edge)
      |=> (st_reg.mode == psm_pkg::PSM_ACTIVE && wake_irq_service && condition_code_push))
    else $error("wait wake missing");
  a_halt_select: assert property (@(posedge clock) disable iff (rst) // [RL7]
    (st_reg.mode == psm_pkg::PSM_ACTIVE && halt_instr && !wait_for_irq_instr)
      |=> (st_reg.mode == ($past(timebase_irq_enable) ? psm_pkg::PSM_AHALT
                                                      : psm_pkg::PSM_HALT)))
    else $error("halt selection wrong");
  a_ahalt_fast: assert property (@(posedge clock) disable iff (rst) // [RL8]
    (st_reg.mode == psm_pkg::PSM_AHALT && timebase_irq && !rst_edge)
      |=> st_reg.mode == psm_pkg::PSM_ACTIVE)
    else $error("active-halt wake delayed");
  a_halt_stab: assert property (@(posedge clock) disable iff (rst) // [RL16]
    (st_reg.mode == psm_pkg::PSM_HALT && !st_reg.guard && irq_halt_wake)
      |=> (st_reg.mode == psm_pkg::PSM_STAB)[*8])
    else $error("halt exit skipped delay");
  a_ahalt_clocks: assert property (@(posedge clock) disable iff (rst) // [RL11]
    (st_reg.mode == psm_pkg::PSM_AHALT) |-> (osc_on && timebase_clk_en && !periph_clk_en))
    else $error("active-halt clocking wrong");
  a_flash_wake: assert property (@(posedge clock) disable iff (rst) // [RL15]
    (FLASH_VARIANT && st_reg.mode == psm_pkg::PSM_AHALT && !timebase_irq && !rst_edge)
      |=> st_reg.mode == psm_pkg::PSM_AHALT)
    else $error("flash part woke wrongly");
  a_slow_rate: assert property (@(posedge clock) disable iff (rst) // [RL2]
    (st_reg.mode == psm_pkg::PSM_ACTIVE && slow_mode_select && cpu_clk_en
      && slow_clock_prescale == 2'h0 && $stable(slow_clock_prescale)) |=> !div_tick)
    else $error("slow divide wrong");

  // Reset, slow wait, stabilisation, guard and priority checks
  a_reset_run: assert property (@(posedge clock) disable iff (rst) // [RL1]
    $fell(rst) |-> (st_reg.mode == psm_pkg::PSM_ACTIVE && cpu_clk_en && periph_clk_en))
    else $error("reset did not land in run");
  a_slow_wait: assert property (@(posedge clock) disable iff (rst) // [RL3]
    (st_reg.mode == psm_pkg::PSM_WAIT && slow_mode_select) |-> (periph_clk_en == div_tick))
    else $error("slow wait rate wrong");
  a_ahalt_reset: assert property (@(posedge clock) disable iff (rst) // [RL9]
    (st_reg.mode == psm_pkg::PSM_AHALT && rst_edge)
      |=> (st_reg.mode == psm_pkg::PSM_STAB && !cpu_reset_out && !wake_irq_service))
    else $error("reset wake skipped delay");
  a_stab_exit: assert property (@(posedge clock) disable iff (rst) // [RL9]
    (st_reg.mode == psm_pkg::PSM_STAB && stab_done)
      |=> (st_reg.mode == psm_pkg::PSM_ACTIVE && cpu_reset_out == $past(st_reg.stab_rst)
           && wake_irq_service != $past(st_reg.stab_rst)))
    else $error("stabilisation exit wrong");
  a_ahalt_entry: assert property (@(posedge clock) disable iff (rst) // [RL10]
    (st_reg.mode == psm_pkg::PSM_ACTIVE && halt_instr && !wait_for_irq_instr && !cpu_prio_we)
      |=> st_reg.prio == `PSM_PRIO_ENABLE)
    else $error("halt entry priority wrong");
  a_guard_halt: assert property (@(posedge clock) disable iff (rst) // [RL13]
    (st_reg.mode == psm_pkg::PSM_ACTIVE && st_reg.guard && stab_busy && !timebase_irq_enable
      && !wait_for_irq_instr && !halt_instr) |=> st_reg.mode == psm_pkg::PSM_HALT)
    else $error("guard halt missing");
  a_wake_push: assert property (@(posedge clock) disable iff (rst) // [RL14]
    wake_irq_service |-> (condition_code_push && condition_code_prio == $past(irq_level)))
    else $error("service entry priority wrong");
  a_prio_restore: assert property (@(posedge clock) disable iff (rst) // [RL14]
    (st_reg.mode == psm_pkg::PSM_ACTIVE && cpu_iret && !cpu_prio_we
      && !wait_for_irq_instr && !halt_instr)
      |=> st_reg.prio == $past(st_reg.saved_prio))
    else $error("priority not restored");
  a_halt_osc: assert property (@(posedge clock) disable iff (rst) // [RL16]
    (st_reg.mode == psm_pkg::PSM_HALT) |-> (!osc_on && !periph_clk_en && !cpu_clk_en))
    else $error("clocks running in halt");
  a_stab_osc: assert property (@(posedge clock) disable iff (rst) // [RL16]
    (st_reg.mode == psm_pkg::PSM_STAB) |-> (osc_on && !periph_clk_en))
    else $error("oscillator off while settling");

  c_wait_cycle: cover property (@(posedge clock) disable iff (rst)
    st_reg.mode == psm_pkg::PSM_WAIT ##1 st_reg.mode == psm_pkg::PSM_ACTIVE);
  c_ahalt_wake: cover property (@(posedge clock) disable iff (rst)
    st_reg.mode == psm_pkg::PSM_AHALT ##1 wake_irq_service);
  c_halt_stab: cover property (@(posedge clock) disable iff (rst)
    st_reg.mode == psm_pkg::PSM_STAB ##1 st_reg.mode == psm_pkg::PSM_ACTIVE);
  c_guard_halt: cover property (@(posedge clock) disable iff (rst)
    st_reg.guard && st_reg.mode == psm_pkg::PSM_HALT);
  c_slow_wait: cover property (@(posedge clock) disable iff (rst)
    st_reg.mode == psm_pkg::PSM_WAIT && slow_mode_select);
endmodule // psm_top
`default_nettype wire

/* psm_cpu_model.sv */
// Purpose: CPU core and interrupt source model for the mode controller
// Assumes: Each request is raised by a one-cycle pulse on raise
// Notes:   Requests clear at vector fetch; return follows IRET_DLY cycles later
`default_nettype none
module psm_cpu_model #(
  parameter int IRET_DLY = 4
) (
  input  wire logic       clock,
  input  wire logic [3:0] raise,
  input  wire logic       wake_irq_service,
  output logic            irq_pending,
  output logic            irq_halt_wake,
  output logic            irq_ahalt_wake,
  output logic            timebase_irq,
  output logic            cpu_iret
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt = 0;
  initial {irq_pending, irq_halt_wake, irq_ahalt_wake, timebase_irq, cpu_iret} = 5'h00;
  // Latch requests, drop them when the service routine is entered
  always @(posedge clock) begin
    if (wake_irq_service) begin
      {timebase_irq, irq_ahalt_wake, irq_halt_wake, irq_pending} <= 4'h0;
      cnt <= IRET_DLY;
    end else begin
      {timebase_irq, irq_ahalt_wake, irq_halt_wake, irq_pending} <=
        {timebase_irq, irq_ahalt_wake, irq_halt_wake, irq_pending} | raise;
      cnt <= (cnt > 0) ? cnt - 1 : 0;
    end
    // Routine ends and pops the condition code
    cpu_iret <= (cnt == 1);
  end
endmodule // psm_cpu_model
`default_nettype wire

/* power_saving_mode_control_bench.sv */
// Purpose: Self-checking bench for the power saving mode controller
// Assumes: Register port answers one cycle after the read strobe
// Notes:   Delay windows allow a few cycles of entry and exit latency
`include "psm_cfg.svh"
`default_nettype none
module power_saving_mode_control_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 1'b0, rst = 1'b1, reg_we = 1'b0, reg_re = 1'b0;
  logic wait_req = 1'b0, halt = 1'b0, rpin = 1'b0;
  logic [`PSM_ADDR_W-1:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  logic [3:0] raise = 4'h0;
  logic irq_p, irq_h, irq_a, tb_irq, iret, cpu_en, per_en, tb_en, osc, wdg, push, svc, rst_out;
  logic [1:0] prio;
  int n_fail = 0, check_count = 0, n;

  always #12.5 clock = ~clock;

  psm_top i_dut (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .wait_for_irq_instr(wait_req),
    .halt_instr(halt), .irq_pending(irq_p), .irq_halt_wake(irq_h), .irq_ahalt_wake(irq_a),
    .timebase_irq(tb_irq), .irq_level(2'h1), .cpu_prio_we(1'b0), .cpu_prio_wdata(2'h0),
    .cpu_iret(iret), .reset_pin_req(rpin), .cpu_clk_en(cpu_en), .periph_clk_en(per_en),
    .timebase_clk_en(tb_en), .osc_on(osc), .wdg_reset_block(wdg),
    .condition_code_prio(prio), .condition_code_push(push), .wake_irq_service(svc),
    .cpu_reset_out(rst_out));

  psm_cpu_model i_cpu (.clock(clock), .raise(raise), .wake_irq_service(svc),
    .irq_pending(irq_p), .irq_halt_wake(irq_h), .irq_ahalt_wake(irq_a),
    .timebase_irq(tb_irq), .cpu_iret(iret));

  // Compare helpers
  task automatic chk8(input string nm, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chk1(input string nm, input logic exp, input logic got);
    chk8(nm, {7'h00, exp}, {7'h00, got});
  endtask
  // Register port cycles
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_we <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge clock);
    reg_we <= 1'b0;
  endtask
  task automatic rd(input string nm, input logic [3:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_re <= 1'b1; reg_addr <= a;
    @(posedge clock);
    reg_re <= 1'b0;
    #1 chk8(nm, exp, reg_rdata);
  endtask
  // Pulse an instruction or request for one cycle
  task automatic pulse(input int k);
    @(posedge clock);
    if (k == 0) wait_req <= 1'b1; else if (k == 1) halt <= 1'b1; else raise <= 4'(k >> 2);
    @(posedge clock);
    {wait_req, halt, raise} <= 6'h00;
    #1;
  endtask
  // Bounded wait for a wake pulse, n counts cycles
  task automatic wait_wake(input int lim);
    for (n = 1; n <= lim && !(svc === 1'b1 || rst_out === 1'b1); n++) @(posedge clock) #1;
    if (n > lim) begin
      n_fail++;
      $display("[FAIL] wake expected within %0d cycles", lim);
      end_of_test();
    end
  endtask
  task automatic end_of_test();
    $display("Checks %0d, failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    #1 chk1("cpu clk after reset", 1'b1, cpu_en);
    rd("status reset", `PSM_OFF_STATUS, 8'h30);
    rd("ctrl reset", `PSM_OFF_CTRL, 8'h00);
    rd("unmapped", 4'h8, 8'h00);
    wr(`PSM_OFF_STATUS, 8'hFF);
    rd("status read only", `PSM_OFF_STATUS, 8'h30);
    $display("test reset done");
    // Slow clock rate for every prescale setting
    for (int s = 0; s < 4; s++) begin
      wr(`PSM_OFF_CTRL, 8'((s << 1) | 1));
      repeat (20) @(posedge clock);
      n = 0;
      repeat (32) begin @(posedge clock); #1 n += cpu_en; end
      chk8("slow enables", 8'(32 >> (s + 1)), 8'(n));
    end
    $display("test slow done");
    // Slow wait, interrupt wake, return
    wr(`PSM_OFF_CTRL, 8'h01);
    pulse(0);
    rd("status slow wait", `PSM_OFF_STATUS, 8'h29);
    chk1("cpu stopped", 1'b0, cpu_en);
    n = 0;
    repeat (32) begin @(posedge clock); #1 n += per_en; end
    chk8("periph slow wait", 8'h10, 8'(n));
    pulse(4);
    wait_wake(8);
    chk1("code push", 1'b1, push);
    chk8("service prio", 8'h01, {6'h00, prio});
    repeat (8) @(posedge clock);
    rd("prio restored", `PSM_OFF_STATUS, 8'h28);
    rd("ctrl kept", `PSM_OFF_CTRL, 8'h01);
    $display("test wait done");
    // Plain wait keeps peripherals on the full master clock
    wr(`PSM_OFF_CTRL, 8'h00);
    pulse(0);
    chk1("periph full rate", 1'b1, per_en);
    chk1("cpu held", 1'b0, cpu_en);
    pulse(4);
    wait_wake(8);
    chk8("plain wake prio", 8'h01, {6'h00, prio});
    repeat (8) @(posedge clock);
    $display("test plain wait done");
    // Active-halt, flash ignores other sources, timebase wakes at once
    wr(`PSM_OFF_CTRL, 8'h08);
    pulse(1);
    rd("status ahalt", `PSM_OFF_STATUS, 8'h22);
    chk1("wdg blocked", 1'b1, wdg);
    chk1("periph off", 1'b0, per_en);
    chk1("timebase on", 1'b1, tb_en & osc);
    pulse(16);
    repeat (10) @(posedge clock);
    rd("flash ignores", `PSM_OFF_STATUS, 8'h22);
    pulse(32);
    wait_wake(4);
    chk1("no delay", 1'b1, n <= 3);
    rd("guard set", `PSM_OFF_STATUS, 8'h50);
    wr(`PSM_OFF_CTRL, 8'h00);
    repeat (8) @(posedge clock);
    rd("guard halt", `PSM_OFF_STATUS, 8'h63);
    chk1("guard osc off", 1'b0, osc);
    repeat (300) @(posedge clock);
    rd("guard over", `PSM_OFF_STATUS, 8'h20);
    wr(`PSM_OFF_CTRL, 8'h08);
    $display("test active halt done");
    // Pending request wakes active-halt entry at once
    pulse(32);
    pulse(1);
    wait_wake(4);
    $display("test pending wake done");
    repeat (4300) @(posedge clock);
    // Full halt with stabilisation delay
    wr(`PSM_OFF_CTRL, 8'h00);
    pulse(1);
    chk1("osc off", 1'b0, osc | per_en);
    pulse(8);
    wait_wake(300);
    chk1("halt delay", 1'b1, n >= 256 && n <= 262);
    $display("test halt done");
    // Reset pin wake from active-halt takes the delay
    repeat (8) @(posedge clock);
    wr(`PSM_OFF_CTRL, 8'h08);
    pulse(1);
    @(posedge clock) rpin <= 1'b1;
    wait_wake(300);
    rpin <= 1'b0;
    chk1("reset wake", 1'b1, rst_out);
    chk1("no service on reset", 1'b0, svc);
    chk1("reset delay", 1'b1, n >= 256 && n <= 266);
    $display("test reset wake done");
    end_of_test();
  end
endmodule // power_saving_mode_control_bench
`default_nettype wire
